// *** rtl/pmcap_pkg.sv ***
// Package for the power-management capability and turn-off handshake block
package pmcap_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] PMCAP_OFS_CAP = 12'h000;
  localparam logic [11:0] PMCAP_OFS_IRQ_STAT = 12'h004;
  localparam logic [11:0] PMCAP_OFS_IRQ_MASK = 12'h008;
  localparam logic [11:0] PMCAP_OFS_CTRL = 12'h00c;

  // ----------------------------------------------------------------
  // Capability register field positions
  // ----------------------------------------------------------------
  localparam int PMCAP_DATA_LSB = 24;
  localparam int PMCAP_STATUS_BIT = 15;
  localparam int PMCAP_SCALE_LSB = 13;
  localparam int PMCAP_SEL_LSB = 9;
  localparam int PMCAP_EN_BIT = 8;
  localparam int PMCAP_STATE_LSB = 0;

  // Reset values
  localparam logic [3:0] PMCAP_SEL_RST = 4'h0;
  localparam logic PMCAP_EN_RST = 1'b0;
  localparam logic [3:0] PMCAP_MASK_RST = 4'h0;
  localparam logic [1:0] PMCAP_CTRL_RST = 2'h0;

  // Interrupt status bits
  localparam int PMCAP_IRQ_TURNOFF = 0;
  localparam int PMCAP_IRQ_WAKE = 1;
  localparam int PMCAP_IRQ_ACK_DONE = 2;
  localparam int PMCAP_IRQ_STATE = 3;

  // Control register bits
  localparam int PMCAP_CTRL_ROOT = 0;
  localparam int PMCAP_CTRL_D3COLD = 1;

  // Power state codes
  typedef enum logic [1:0] {
    PMCAP_D0 = 2'h0,
    PMCAP_D1 = 2'h1,
    PMCAP_D2 = 2'h2,
    PMCAP_D3 = 2'h3
  } pmcap_state_t;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmcap_apb_req_t;

  // Link-side message strobes
  typedef struct packed {
    logic turnoff_msg;
    logic ack_msg;
  } pmcap_link_msg_t;

endpackage

// *** rtl/pmcap_handshake.sv ***
// Turn-off message handshake between the link and the application
`timescale 1ns/1ps
module pmcap_handshake (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Mode
  input wire logic root_mode,
  // Link side
  input wire pmcap_pkg::pmcap_link_msg_t link_rx,
  output logic link_tx_turnoff_q,
  output logic link_tx_ack_q,
  // Application side
  input wire logic turnoff_ack_request,
  output logic turnoff_notice_pulse,
  output logic ack_seen_q
);

  logic req_prev_q;
  wire req_rise;
  wire endpoint_notice;
  wire root_notice;

  // Edge detect so a held request sends one message, not one per cycle
  assign req_rise = turnoff_ack_request & ~req_prev_q;
  assign endpoint_notice = ~root_mode & link_rx.turnoff_msg;
  assign root_notice = root_mode & link_rx.ack_msg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_prev_q <= 1'b0;
      link_tx_turnoff_q <= 1'b0;
      link_tx_ack_q <= 1'b0;
      turnoff_notice_pulse <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      req_prev_q <= turnoff_ack_request;
      link_tx_turnoff_q <= root_mode & req_rise;
      link_tx_ack_q <= ~root_mode & req_rise;
      turnoff_notice_pulse <= endpoint_notice | root_notice;
      ack_seen_q <= root_notice;
    end
  end

endmodule

// *** rtl/pmcap_regs.sv ***
// Power-management capability register bank with APB access and turn-off handshake
// ----------------------------------------------------------------
// Notes on behaviour
// - The top byte of the capability register holds an eight-bit data value for the selected quantity.
// - The pending-event status bit is set on every wake condition whether or not wake is enabled.
// - The two-bit scale field is supplied by the function and software writes cannot change it.
// - A four-bit software selector picks which quantity the data and scale fields report.
// - A wake message leaves the block only while the wake enable bit is one.
// - The two low bits encode the power state, 00 D0, 01 D1, 10 D2, 11 D3.
// - State 11 with the auxiliary-power indication means D3-Cold, otherwise D3-Hot.
// - An endpoint raises its turn-off notice when a turn-off message arrives.
// - In an endpoint the turn-off notice is high for exactly one clock per message.
// - A root port sends a turn-off message when the acknowledge request input rises.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module pmcap_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Function status inputs
  input wire logic [1:0] power_state_code,
  input wire logic aux_power_type,
  input wire logic [7:0] fn_data_value,
  input wire logic [1:0] fn_data_scale,
  input wire logic wake_condition,
  // Link side
  input wire logic link_rx_turnoff,
  input wire logic link_rx_ack,
  output logic link_tx_turnoff,
  output logic link_tx_ack,
  output logic link_tx_wake,
  // Application side
  input wire logic turnoff_ack_request,
  output logic turnoff_notice_pulse,
  output logic [3:0] data_select_out,
  output logic d3_cold,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0] sel_q;
  logic wake_en_q;
  logic wake_status_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [1:0] ctrl_q;
  logic [1:0] state_prev_q;
  logic wake_prev_q;
  logic wake_tx_q;
  logic d3_cold_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_d;
  logic [3:0] irq_stat_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] pmcap_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Full-word compare: offsets are word aligned, so the low address bits must match too
  function automatic logic pmcap_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

  pmcap_pkg::pmcap_apb_req_t req;
  wire setup_ph;
  wire wr_acc;
  wire sel_cap;
  wire sel_stat;
  wire sel_mask;
  wire sel_ctrl;
  wire addr_ok;
  wire [31:0] cap_word;
  wire [31:0] cap_wr;
  wire [31:0] stat_wr;
  wire [31:0] mask_wr;
  wire [31:0] ctrl_wr;
  wire wake_rise;
  wire state_change;
  wire notice;
  wire ack_seen;
  wire tx_turnoff;
  wire tx_ack;
  wire wr_cap;
  wire wr_stat;
  wire wr_mask;
  wire wr_ctrl;
  wire wake_clr;
  wire ev_turnoff;
  wire ev_wake;
  wire ev_ack;
  wire ev_state;
  wire irq_d;
  pmcap_pkg::pmcap_link_msg_t link_rx;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  // Zero-wait slave: the answer is registered in the setup cycle, so access lasts one cycle
  assign setup_ph = req.psel & ~req.penable;
  assign wr_acc = req.psel & req.penable & req.pwrite & pready_q;
  assign sel_cap = pmcap_hit(req.paddr, pmcap_pkg::PMCAP_OFS_CAP);
  assign sel_stat = pmcap_hit(req.paddr, pmcap_pkg::PMCAP_OFS_IRQ_STAT);
  assign sel_mask = pmcap_hit(req.paddr, pmcap_pkg::PMCAP_OFS_IRQ_MASK);
  assign sel_ctrl = pmcap_hit(req.paddr, pmcap_pkg::PMCAP_OFS_CTRL);
  assign addr_ok = sel_cap | sel_stat | sel_mask | sel_ctrl;

  // Write strobes per register, true only at the edge that completes the access
  assign wr_cap = wr_acc & sel_cap;
  assign wr_stat = wr_acc & sel_stat;
  assign wr_mask = wr_acc & sel_mask;
  assign wr_ctrl = wr_acc & sel_ctrl;

  // ----------------------------------------------------------------
  // Capability word
  // ----------------------------------------------------------------
  assign cap_word = {fn_data_value,
                     1'b0, 7'h00,
                     wake_status_q,
                     fn_data_scale,
                     sel_q,
                     wake_en_q,
                     6'h00,
                     power_state_code};

  assign cap_wr = pmcap_merge(cap_word, req.pwdata, pstrb);
  assign stat_wr = pmcap_merge(32'h0000_0000, req.pwdata, pstrb);
  assign mask_wr = pmcap_merge({28'h0000000, irq_mask_q}, req.pwdata, pstrb);
  assign ctrl_wr = pmcap_merge({30'h00000000, ctrl_q}, req.pwdata, pstrb);

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (sel_cap) begin
      prdata_d = cap_word;
    end else if (sel_stat) begin
      prdata_d = {28'h0000000, irq_stat_q};
    end else if (sel_mask) begin
      prdata_d = {28'h0000000, irq_mask_q};
    end else if (sel_ctrl) begin
      prdata_d = {30'h00000000, ctrl_q};
    end
  end

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  assign wake_rise = wake_condition & ~wake_prev_q;
  assign state_change = (power_state_code != state_prev_q);
  assign link_rx = '{turnoff_msg: link_rx_turnoff, ack_msg: link_rx_ack};
  assign wake_clr = wr_cap & pstrb[1] & cap_wr[pmcap_pkg::PMCAP_STATUS_BIT];
  // A root port flags the received ack on its own bit, so it must not also flag a turn-off
  assign ev_turnoff = notice & ~ack_seen;
  assign ev_wake = wake_rise;
  assign ev_ack = ack_seen;
  assign ev_state = state_change;
  assign irq_d = |(irq_stat_d & irq_mask_q);

  // Set beats clear: a new event in the write-one-to-clear cycle survives
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_stat) begin
      irq_stat_d = irq_stat_q & ~stat_wr[3:0];
    end
    irq_stat_d[pmcap_pkg::PMCAP_IRQ_TURNOFF] = irq_stat_d[pmcap_pkg::PMCAP_IRQ_TURNOFF] | ev_turnoff;
    irq_stat_d[pmcap_pkg::PMCAP_IRQ_WAKE] = irq_stat_d[pmcap_pkg::PMCAP_IRQ_WAKE] | ev_wake;
    irq_stat_d[pmcap_pkg::PMCAP_IRQ_ACK_DONE] = irq_stat_d[pmcap_pkg::PMCAP_IRQ_ACK_DONE] | ev_ack;
    irq_stat_d[pmcap_pkg::PMCAP_IRQ_STATE] = irq_stat_d[pmcap_pkg::PMCAP_IRQ_STATE] | ev_state;
  end

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  pmcap_handshake u_handshake (
    .pclk(pclk),
    .presetn(presetn),
    .root_mode(ctrl_q[pmcap_pkg::PMCAP_CTRL_ROOT]),
    .link_rx(link_rx),
    .link_tx_turnoff_q(tx_turnoff),
    .link_tx_ack_q(tx_ack),
    .turnoff_ack_request(turnoff_ack_request),
    .turnoff_notice_pulse(notice),
    .ack_seen_q(ack_seen)
  );

  assign link_tx_turnoff = tx_turnoff;
  assign link_tx_ack = tx_ack;
  assign turnoff_notice_pulse = notice;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= pmcap_pkg::PMCAP_SEL_RST;
      wake_en_q <= pmcap_pkg::PMCAP_EN_RST;
    end else if (wr_cap) begin
      sel_q <= cap_wr[pmcap_pkg::PMCAP_SEL_LSB +: 4];
      wake_en_q <= cap_wr[pmcap_pkg::PMCAP_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= pmcap_pkg::PMCAP_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_q <= mask_wr[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pmcap_pkg::PMCAP_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_wr[1:0];
    end
  end

  // Pending status is sticky until software writes one to it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_status_q <= 1'b0;
    end else if (wake_condition) begin
      wake_status_q <= 1'b1;
    end else if (wake_clr) begin
      wake_status_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_prev_q <= 2'h0;
      wake_prev_q <= 1'b0;
    end else begin
      state_prev_q <= power_state_code;
      wake_prev_q <= wake_condition;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_tx_q <= 1'b0;
      d3_cold_q <= 1'b0;
    end else begin
      wake_tx_q <= wake_rise & wake_en_q;
      d3_cold_q <= (power_state_code == pmcap_pkg::PMCAP_D3) & aux_power_type;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~addr_ok;
    end
  end

  // Captured in the setup cycle so the word stands unchanged through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph && !req.pwrite) begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link_tx_wake = wake_tx_q;
  assign data_select_out = sel_q;
  assign d3_cold = d3_cold_q;
  assign irq = irq_q;

endmodule

// *** tb/pmcap_regs_asserts.sv ***
// Port checker for the capability register bank and turn-off handshake
`timescale 1ns/1ps
module pmcap_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Function and link
  input wire logic [1:0] power_state_code,
  input wire logic aux_power_type,
  input wire logic [7:0] fn_data_value,
  input wire logic [1:0] fn_data_scale,
  input wire logic wake_condition,
  input wire logic link_rx_turnoff,
  input wire logic link_rx_ack,
  input wire logic link_tx_turnoff,
  input wire logic link_tx_ack,
  input wire logic link_tx_wake,
  input wire logic turnoff_ack_request,
  input wire logic turnoff_notice_pulse,
  input wire logic [3:0] data_select_out,
  input wire logic d3_cold
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire cap_rd = pready && !pwrite && paddr == 12'h000;
  AST_DATA: assert property (cap_rd |-> prdata[31:24] == $past(fn_data_value)) else $error("data byte");
  AST_SCALE: assert property (cap_rd |-> prdata[14:13] == $past(fn_data_scale)) else $error("scale");
  AST_SEL: assert property (cap_rd |-> prdata[12:9] == data_select_out) else $error("select");
  AST_STATE: assert property (cap_rd |-> prdata[1:0] == $past(power_state_code)) else $error("state");
  AST_RSVD: assert property (cap_rd |-> prdata[23:16] == 8'h00 && prdata[7:2] == 6'h00) else $error("rsvd");
  AST_WAKE: assert property (link_tx_wake |-> $past(wake_condition) && !$past(wake_condition, 2))
    else $error("wake cause");
  AST_D3: assert property (##1 d3_cold == $past(power_state_code == 2'h3 && aux_power_type))
    else $error("d3 cold");
  AST_NOTE: assert property (turnoff_notice_pulse |-> $past(link_rx_turnoff || link_rx_ack))
    else $error("notice cause");
  AST_ONE: assert property (turnoff_notice_pulse && !link_rx_turnoff && !link_rx_ack |=> !turnoff_notice_pulse)
    else $error("notice width");
  AST_TX: assert property (link_tx_turnoff || link_tx_ack |-> $past(turnoff_ack_request)
    && !$past(turnoff_ack_request, 2) && !(link_tx_turnoff && link_tx_ack)) else $error("tx cause");
endmodule
bind pmcap_regs pmcap_chk u_chk (.pclk, .presetn, .pwrite, .paddr, .prdata, .pready, .power_state_code,
  .aux_power_type, .fn_data_value, .fn_data_scale, .wake_condition, .link_rx_turnoff, .link_rx_ack,
  .link_tx_turnoff, .link_tx_ack, .link_tx_wake, .turnoff_ack_request, .turnoff_notice_pulse,
  .data_select_out, .d3_cold);

// *** tb/pmcap_app_model.sv ***
// Application partner that answers each turn-off notice with an acknowledge request
`timescale 1ns/1ps
module pmcap_app_model #(
  parameter int DELAY = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Handshake
  input wire logic turnoff_notice_pulse,
  output logic turnoff_ack_request
);
  int cnt;
  // Request held two cycles: only its rise may count as one acknowledge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      turnoff_ack_request <= 1'b0;
    end else begin
      if (turnoff_notice_pulse)
        cnt <= DELAY + 2;
      else if (cnt > 0)
        cnt <= cnt - 1;
      turnoff_ack_request <= cnt > 0 && cnt <= 2;
    end
  end
endmodule

// *** tb/pm_capability_turnoff_bench.sv ***
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
module pm_capability_turnoff_bench;
  logic pclk, presetn, psel, penable, pwrite, aux_power_type, wake_condition, err;
  logic link_rx_turnoff, link_rx_ack, turnoff_ack_request, pready, pslverr, irq, d3_cold;
  logic link_tx_turnoff, link_tx_ack, link_tx_wake, turnoff_notice_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, data_select_out;
  logic [1:0] power_state_code, fn_data_scale;
  logic [7:0] fn_data_value;
  int errors, check_count, n_note, n_ack, n_off, n_wake;
  pmcap_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .power_state_code, .aux_power_type, .fn_data_value, .fn_data_scale, .wake_condition, .link_rx_turnoff,
    .link_rx_ack, .link_tx_turnoff, .link_tx_ack, .link_tx_wake, .turnoff_ack_request, .turnoff_notice_pulse,
    .data_select_out, .d3_cold, .irq);
  pmcap_app_model u_app (.pclk, .presetn, .turnoff_notice_pulse, .turnoff_ack_request);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_note += int'(turnoff_notice_pulse === 1'b1);
    n_ack += int'(link_tx_ack === 1'b1);
    n_off += int'(link_tx_turnoff === 1'b1);
    n_wake += int'(link_tx_wake === 1'b1);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rx(input logic is_ack);
    @(posedge pclk);
    link_rx_ack <= is_ack;
    link_rx_turnoff <= !is_ack;
    @(posedge pclk);
    link_rx_ack <= 1'b0;
    link_rx_turnoff <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic wake;
    @(posedge pclk);
    wake_condition <= 1'b1;
    repeat (3) @(posedge pclk);
    wake_condition <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, wake_condition, link_rx_turnoff, link_rx_ack, aux_power_type} = '0;
    paddr = 12'h000;
    pwdata = '0;
    pstrb = 4'hf;
    power_state_code = 2'h0;
    fn_data_value = 8'h72;
    fn_data_scale = 2'h2;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pmcap_pkg::PMCAP_OFS_CAP, '0);
    chk(rd, 32'h7200_4000);
    apb(1'b1, pmcap_pkg::PMCAP_OFS_CAP, 32'hffff_ffff);
    apb(1'b0, pmcap_pkg::PMCAP_OFS_CAP, '0);
    chk(rd, 32'h7200_5f00);
    chk(32'(data_select_out), 32'hf);
    wake();
    apb(1'b0, pmcap_pkg::PMCAP_OFS_CAP, '0);
    chk(rd, 32'h7200_df00);
    apb(1'b1, pmcap_pkg::PMCAP_OFS_CAP, 32'h0000_8000);
    wake();
    // Lane 0 only: status, selector and enable sit in lane 1 and must survive
    pstrb <= 4'h1;
    apb(1'b1, pmcap_pkg::PMCAP_OFS_CAP, 32'hffff_ffff);
    pstrb <= 4'hf;
    apb(1'b0, pmcap_pkg::PMCAP_OFS_CAP, '0);
    chk(rd, 32'h7200_c000);
    chk(32'(n_wake), 32'h1);
    for (int s = 0; s < 8; s++) begin
      power_state_code <= s[1:0];
      aux_power_type <= s[2];
      fn_data_value <= 8'h72 ^ 8'(s);
      fn_data_scale <= s[2:1];
      apb(1'b0, pmcap_pkg::PMCAP_OFS_CAP, '0);
      chk(rd, {8'h72 ^ 8'(s), 8'h00, 1'b1, s[2:1], 11'h000, s[1:0]});
      chk(32'(d3_cold), 32'(s[1:0] == 2'h3 && s[2]));
    end
    chk(32'(irq), 32'h0);
    apb(1'b1, pmcap_pkg::PMCAP_OFS_IRQ_MASK, 32'h1);
    rx(1'b0);
    chk(32'(n_note), 32'h1);
    chk(32'(n_ack), 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b1, pmcap_pkg::PMCAP_OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, pmcap_pkg::PMCAP_OFS_CTRL, 32'h1);
    rx(1'b1);
    chk(32'(n_note), 32'h2);
    chk(32'(n_off), 32'h1);
    chk(32'(n_ack), 32'h1);
    // Turn-off was cleared; wake, root ack and state change are still pending
    apb(1'b0, pmcap_pkg::PMCAP_OFS_IRQ_STAT, '0);
    chk(rd, 32'h0000_000e);
    apb(1'b0, 12'h010, '0);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h1);
    summarize();
  end
endmodule
